// [bench/swp_bench.sv]
// testbench: master and slave ends joined on one line, driven at the master command port
`timescale 1ns/1ps
module swp_bench import swp_pkg::*;;
	localparam int RST_N = 7000;
	localparam int COPY_N = 500;
	localparam int DET_N = 6000;
	localparam int PLOW_N = 5000;
	localparam int BYTE_N = 8 * (SLOT_TIME_CYC + RECOVERY_TIME_CYC) + 50;
	logic clk = 1'b0;
	logic rstn;
	logic cmd_valid;
	logic cmd_ready;
	logic [1:0] cmd_op;
	logic [7:0] cmd_data;
	logic presence;
	logic rx_valid;
	logic rx_ready;
	logic [7:0] rx_data;
	logic lock_enable;
	logic copy_busy_flag;
	logic sleep_mode;
	logic selected;
	logic saw_sleep = 1'b0;
	int errors = 0;
	int check_count = 0;
	int n;
	// ==========================================
	// clock and parts
	always #10 clk = ~clk;
	always @(posedge clk)
		if (sleep_mode === 1'b1)
			saw_sleep <= 1'b1;
	swp_if swp_if_i();
	swp_master_end #(.RST_LOW_CYC(RST_N), .RST_HIGH_CYC(RST_N), .BUF_DEPTH(2)) swp_master_end_i (
		.clk(clk), .rstn(rstn), .bus(swp_if_i.master), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .presence(presence), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data));
	// sleep limit below the reset low time so every reset also exercises sleep entry and exit
	swp_slave_end #(.RESET_DET_CYC(DET_N), .PRES_LOW_CYC(PLOW_N), .SLEEP_CYC(6500), .COPY_CYC(COPY_N)) swp_slave_end_i (
		.clk(clk), .rstn(rstn), .bus(swp_if_i.slave), .lock_enable(lock_enable),
		.copy_busy_flag(copy_busy_flag), .sleep_mode(sleep_mode), .selected(selected));
	swp_properties #(.RESET_DET_CYC(DET_N), .PRES_LOW_CYC(PLOW_N)) swp_properties_i (
		.clk(clk), .rstn(rstn), .master_oe_n(swp_if_i.master_oe_n),
		.slave_oe_n(swp_if_i.slave_oe_n), .dq(swp_if_i.dq));
	// ==========================================
	// tasks
	task check1(input string what, input logic exp, input logic got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wait_ready();
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < BYTE_N + 2 * RST_N)
		begin
			@(posedge clk);
			#2;
			k++;
		end
		check1("cmd_ready", 1'b1, cmd_ready);
	endtask
	task send(input logic [1:0] op, input logic [7:0] d, input logic done);
		cmd_op = op;
		cmd_data = d;
		cmd_valid = 1'b1;
		wait_ready();
		@(posedge clk);
		#2;
		cmd_valid = 1'b0;
		if (done)
			wait_ready();
	endtask
	task start_cmd(input logic [7:0] op);
		send(SWP_CMD_RESET, 8'h00, 1'b1);
		check1("presence", 1'b1, presence);
		check1("selected", 1'b0, selected);
		check1("saw_sleep", 1'b1, saw_sleep);
		check1("sleep_mode", 1'b0, sleep_mode);
		send(SWP_CMD_WRITE, OP_SKIP_NET, 1'b1);
		check1("selected", 1'b1, selected);
		send(SWP_CMD_WRITE, op, 1'b1);
	endtask
	task pop(input logic [7:0] exp);
		wait (rx_valid === 1'b1);
		check8("rx_data", exp, rx_data);
		rx_ready = 1'b1;
		@(posedge clk);
		#2;
		rx_ready = 1'b0;
	endtask
	task wrap_up();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// tests
	initial
	begin
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = 2'b00;
		cmd_data = 8'h00;
		rx_ready = 1'b0;
		lock_enable = 1'b0;
		repeat (3) @(posedge clk);
		#2;
		rstn = 1'b1;
		start_cmd(OP_WRITE);
		send(SWP_CMD_WRITE, 8'h1f, 1'b1);
		send(SWP_CMD_WRITE, 8'ha5, 1'b1);
		send(SWP_CMD_WRITE, 8'h3c, 1'b1);
		$display("test write done");
		// receiver stalls: the master must refuse once both entries are full
		start_cmd(OP_READ);
		send(SWP_CMD_WRITE, 8'h1f, 1'b1);
		send(SWP_CMD_READ, 8'h00, 1'b1);
		send(SWP_CMD_READ, 8'h00, 1'b0);
		repeat (BYTE_N) @(posedge clk);
		#2;
		check1("cmd_ready", 1'b0, cmd_ready);
		pop(8'ha5);
		pop(8'h3c);
		wait_ready();
		$display("test read done");
		start_cmd(OP_COPY);
		send(SWP_CMD_WRITE, 8'h20, 1'b0);
		n = 0;
		while (copy_busy_flag !== 1'b1 && n < BYTE_N)
		begin
			@(posedge clk);
			#2;
			n++;
		end
		n = 0;
		while (copy_busy_flag === 1'b1 && n < 2 * COPY_N)
		begin
			@(posedge clk);
			#2;
			n++;
		end
		check1("copy_busy_flag", 1'b1, n >= COPY_N - 1 && n <= COPY_N + 1);
		wait_ready();
		$display("test copy done");
		wrap_up();
	end
	initial
	begin
		#12_000_000;
		errors++;
		wrap_up();
	end
endmodule

// [bench/swp_properties.sv]
// checker: timing relations seen on the shared single-wire line
`timescale 1ns/1ps
module swp_properties #(
	parameter int RESET_DET_CYC = 6000,
	parameter int PRES_LOW_CYC = 5000
)(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// line
	input wire logic master_oe_n,
	input wire logic slave_oe_n,
	input wire logic dq
);
	int line_low;
	int m_low;
	int s_low;
	int pres_wait;
	logic pres_armed;
	// ==========================================
	// run counters: these runs last thousands of cycles, too long for repetition
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			line_low <= 0;
			m_low <= 0;
			s_low <= 0;
		end
		else
		begin
			line_low <= dq ? 0 : line_low + 1;
			m_low <= master_oe_n ? 0 : m_low + 1;
			s_low <= slave_oe_n ? 0 : s_low + 1;
		end
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pres_armed <= 1'b0;
		else if (dq && line_low > RESET_DET_CYC)
			pres_armed <= 1'b1;
		else if (slave_oe_n && s_low != 0)
			pres_armed <= 1'b0;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			pres_wait <= 0;
		else if (!pres_armed)
			pres_wait <= 0;
		else if (slave_oe_n)
			pres_wait <= pres_wait + 1;
	end
	// ==========================================
	// properties
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	property p_pres_wait;
		$fell(slave_oe_n) && pres_armed |-> pres_wait >= 740;
	endproperty
	a_pres_wait: assert property (p_pres_wait)
		else $error("presence started too soon");
	property p_pres_late;
		pres_armed && slave_oe_n |-> pres_wait < 3000;
	endproperty
	a_pres_late: assert property (p_pres_late)
		else $error("presence missing");
	property p_pres_len;
		$rose(slave_oe_n) && pres_armed |-> s_low inside {[PRES_LOW_CYC - 1:PRES_LOW_CYC + 1]};
	endproperty
	a_pres_len: assert property (p_pres_len)
		else $error("presence length off");
	property p_slave_start;
		$fell(slave_oe_n) |-> !master_oe_n || pres_armed;
	endproperty
	a_slave_start: assert property (p_slave_start)
		else $error("slave pulled an idle line");
	property p_read_release;
		!slave_oe_n && !pres_armed |-> s_low < 3000;
	endproperty
	a_read_release: assert property (p_read_release)
		else $error("read zero held past slot");
	property p_read_hold;
		$rose(slave_oe_n) && !pres_armed |-> s_low >= 700;
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("read zero released before sample");
	property p_master_low;
		$rose(master_oe_n) |-> m_low inside {[50:750]} || m_low inside {[3000:6000]} || m_low > RESET_DET_CYC;
	endproperty
	a_master_low: assert property (p_master_low)
		else $error("master low time out of range");
	property p_recovery;
		$rose(master_oe_n) |-> master_oe_n throughout (##49 1'b1);
	endproperty
	a_recovery: assert property (p_recovery)
		else $error("recovery too short");
	property p_reset_quiet;
		line_low > RESET_DET_CYC |-> slave_oe_n;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("slave drives during reset");
	c_presence: cover property ($rose(slave_oe_n) && pres_armed);
	c_read_zero: cover property ($rose(slave_oe_n) && !pres_armed);
	c_write_zero: cover property ($rose(master_oe_n) && m_low >= 3000);
endmodule

// [logic/swp_fifo.sv]
// module: small valid/ready buffer for received bytes
`timescale 1ns/1ps
module swp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
)(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0] count_reg;
	logic [PW:0] count_next;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_reg[rd_ptr_reg];

	always_comb
	begin
		count_next = count_reg;
		if (push && !pop)
			count_next = count_reg + 1'b1;
		else if (pop && !push)
			count_next = count_reg - 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (push)
			mem_reg[wr_ptr_reg] <= in_data;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg <= count_next;
			// flags held in flops so both sides see clean registered handshakes
			in_ready <= (count_next != DEPTH_C);
			out_valid <= (count_next != '0);
		end
	end
endmodule

// [logic/swp_if.sv]
// interface: open-drain data line shared by the master end and the slave end
`timescale 1ns/1ps
interface swp_if;
	logic master_out;
	logic master_oe_n;
	logic slave_out;
	logic slave_oe_n;
	wire dq;
	// wired-and with pull-up: any enabled driver pulls the line to its (low) output
	assign dq = (master_oe_n | master_out) & (slave_oe_n | slave_out);
	modport master (output master_out, output master_oe_n, input dq);
	modport slave (output slave_out, output slave_oe_n, input dq);
endinterface

// [logic/swp_master_end.sv]
// module: master end, generates reset, write and read slots and collects read bytes
`timescale 1ns/1ps
module swp_master_end import swp_pkg::*; #(
	parameter int RST_LOW_CYC = RESET_LOW_TIME_CYC,
	parameter int RST_HIGH_CYC = RESET_HIGH_CYC,
	parameter int BUF_DEPTH = 2
)(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// line
	swp_if.master bus,
	// command
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_data,
	output logic presence,
	// received bytes
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data
);
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_RLOW = 3'b001,
		HS_RWAIT = 3'b010,
		HS_SLOT = 3'b011,
		HS_REC = 3'b100
	} swp_hstate_t;

	swp_hstate_t state_reg;
	logic [15:0] cnt_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic reading_reg;
	logic oe_n_reg;
	logic push_reg;
	logic buf_in_ready;

	assign bus.master_out = 1'b0;
	assign bus.master_oe_n = oe_n_reg;

	swp_fifo #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_rx_buf (
		.clk(clk),
		.rstn(rstn),
		.in_valid(push_reg),
		.in_ready(buf_in_ready),
		.in_data(shift_reg),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);

	// ==========================================
	// slot sequencer
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= HS_IDLE;
			cnt_reg <= '0;
			shift_reg <= 8'hff;
			bit_cnt_reg <= '0;
			reading_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			push_reg <= 1'b0;
			cmd_ready <= 1'b0;
			presence <= 1'b0;
		end
		else
		begin
			push_reg <= 1'b0;
			cnt_reg <= cnt_reg + 1'b1;
			case (state_reg)
				HS_IDLE:
				begin
					cnt_reg <= '0;
					if (cmd_valid && cmd_ready)
					begin
						// every transfer is started by this end
						cmd_ready <= 1'b0;
						oe_n_reg <= 1'b0;
						bit_cnt_reg <= '0;
						reading_reg <= (cmd_op == SWP_CMD_READ);
						shift_reg <= (cmd_op == SWP_CMD_READ) ? 8'hff : cmd_data;
						state_reg <= (cmd_op == SWP_CMD_RESET) ? HS_RLOW : HS_SLOT;
					end
					else
						cmd_ready <= buf_in_ready; // stall while no room for a read byte
				end
				HS_RLOW:
				begin
					if (cnt_reg == 16'(RST_LOW_CYC - 1))
					begin
						oe_n_reg <= 1'b1;
						cnt_reg <= '0;
						state_reg <= HS_RWAIT;
					end
				end
				HS_RWAIT:
				begin
					if (cnt_reg == 16'(PRESENCE_SAMPLE_CYC))
						presence <= ~bus.dq;
					if (cnt_reg == 16'(RST_HIGH_CYC - 1))
						state_reg <= HS_IDLE;
				end
				HS_SLOT:
				begin
					// a one or a read start is released early, a zero is held the whole slot
					if (cnt_reg == 16'(WRITE1_LOW_CYC) && (reading_reg || shift_reg[0]))
						oe_n_reg <= 1'b1;
					if (reading_reg && cnt_reg == 16'(READ_VALID_TIME_CYC))
						shift_reg <= {bus.dq, shift_reg[7:1]};
					if (cnt_reg == 16'(SLOT_TIME_CYC - 1))
					begin
						oe_n_reg <= 1'b1;
						if (!reading_reg)
							shift_reg <= {1'b1, shift_reg[7:1]};
						cnt_reg <= '0;
						state_reg <= HS_REC;
					end
				end
				HS_REC:
				begin
					if (cnt_reg == 16'(RECOVERY_TIME_CYC - 1))
					begin
						cnt_reg <= '0;
						if (bit_cnt_reg == 3'd7)
						begin
							push_reg <= reading_reg;
							state_reg <= HS_IDLE;
						end
						else
						begin
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
							oe_n_reg <= 1'b0;
							state_reg <= HS_SLOT;
						end
					end
				end
				default:
					state_reg <= HS_IDLE;
			endcase
		end
	end
endmodule

// [logic/swp_pkg.sv]
// package: timing, opcodes and memory layout shared by both ends of the single-wire port
package swp_pkg;
	// ==========================================
	// clock
	localparam int CLK_PERIOD_NS = 20;
	localparam int NS_PER_US = 1000;
	// ==========================================
	// slave timing (microseconds or milliseconds, then cycles)
	localparam int RESET_DETECT_US = 120;
	localparam int RESET_DETECT_CYC = RESET_DETECT_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int PRESENCE_WAIT_US = 30;
	localparam int PRESENCE_WAIT_CYC = PRESENCE_WAIT_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int PRESENCE_LOW_US = 100;
	localparam int PRESENCE_LOW_CYC = PRESENCE_LOW_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int SAMPLE_POINT_US = 30;
	localparam int SAMPLE_POINT_CYC = SAMPLE_POINT_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int IDLE_LOW_SLEEP_MS = 2100;
	localparam int IDLE_LOW_SLEEP_CYC = IDLE_LOW_SLEEP_MS * 1000 * (NS_PER_US / CLK_PERIOD_NS);
	localparam int COPY_TIME_US = 2000;
	localparam int COPY_TIME_CYC = COPY_TIME_US * NS_PER_US / CLK_PERIOD_NS;
	// ==========================================
	// master timing
	localparam int RESET_LOW_TIME_US = 480;
	localparam int RESET_LOW_TIME_CYC = (RESET_LOW_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESET_HIGH_US = 480;
	localparam int RESET_HIGH_CYC = (RESET_HIGH_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PRESENCE_SAMPLE_US = 70;
	localparam int PRESENCE_SAMPLE_CYC = PRESENCE_SAMPLE_US * NS_PER_US / CLK_PERIOD_NS;
	localparam int SLOT_TIME_US = 70;
	localparam int SLOT_TIME_CYC = (SLOT_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVERY_TIME_US = 2;
	localparam int RECOVERY_TIME_CYC = (RECOVERY_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE1_LOW_US = 5;
	localparam int WRITE1_LOW_CYC = (WRITE1_LOW_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_VALID_TIME_US = 13;
	localparam int READ_VALID_TIME_CYC = READ_VALID_TIME_US * NS_PER_US / CLK_PERIOD_NS;
	// ==========================================
	// opcodes
	localparam logic [7:0] OP_SKIP_NET = 8'hcc;
	localparam logic [7:0] OP_READ = 8'h69;
	localparam logic [7:0] OP_WRITE = 8'h6c;
	localparam logic [7:0] OP_COPY = 8'h48;
	localparam logic [7:0] OP_RECALL = 8'hb8;
	localparam logic [7:0] OP_LOCK = 8'h6a;
	// ==========================================
	// memory layout: nonvolatile blocks of 16 bytes
	localparam logic [7:0] NV_BASE = 8'h20;
	localparam int NV_BLOCKS = 2;
	localparam int NV_BLOCK_BYTES = 16;
	localparam logic [7:0] MEM_RESET_VALUE = 8'h00;
	localparam logic [7:0] ADDR_LAST = 8'hff;
	// ==========================================
	// master command codes
	typedef enum logic [1:0] {
		SWP_CMD_RESET = 2'b00,
		SWP_CMD_WRITE = 2'b01,
		SWP_CMD_READ = 2'b10
	} swp_cmd_t;
endpackage

// [logic/swp_slave_end.sv]
// module: slave end, presence, slot decoding, memory function commands and sleep detection
// ==========================================
`timescale 1ns/1ps
module swp_slave_end import swp_pkg::*; #(
	parameter int RESET_DET_CYC = RESET_DETECT_CYC,
	parameter int PRES_LOW_CYC = PRESENCE_LOW_CYC,
	parameter int SLEEP_CYC = IDLE_LOW_SLEEP_CYC,
	parameter int COPY_CYC = COPY_TIME_CYC
)(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// line
	swp_if.slave bus,
	// control and status
	input wire logic lock_enable,
	output logic copy_busy_flag,
	output logic sleep_mode,
	output logic selected
);
	typedef enum logic [3:0] {
		SS_IDLE = 4'b0000,
		SS_PWAIT = 4'b0001,
		SS_PLOW = 4'b0010,
		SS_ROM = 4'b0011,
		SS_FUNC = 4'b0100,
		SS_ADDR = 4'b0101,
		SS_WDATA = 4'b0110,
		SS_RDATA = 4'b0111,
		SS_HALT = 4'b1000
	} swp_sstate_t;

	localparam int NV_BYTES = NV_BLOCKS * NV_BLOCK_BYTES;

	swp_sstate_t state_reg;
	logic dq_prev_reg;
	logic [26:0] low_cnt_reg;
	logic [15:0] cnt_reg;
	logic slot_reg;
	logic [7:0] shift_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] op_reg;
	logic [7:0] addr_reg;
	logic past_end_reg;
	logic oe_n_reg;
	logic [7:0] mem_reg [256];
	logic [7:0] nv_reg [NV_BYTES];
	logic [NV_BLOCKS-1:0] locked_reg;
	logic [16:0] copy_cnt_reg;
	logic [7:0] copy_base_reg;
	logic fall;
	logic rise;
	logic sample_ev;
	logic byte_ev;
	logic [7:0] rx_byte;
	logic cmd_ev;
	logic wr_ev;

	// ==========================================
	// address helpers
	function automatic logic is_nv(input logic [7:0] a);
		is_nv = (a >= NV_BASE) && (a < NV_BASE + 8'(NV_BYTES));
	endfunction

	function automatic int blk_of(input logic [7:0] a);
		blk_of = int'(a - NV_BASE) / NV_BLOCK_BYTES;
	endfunction

	function automatic logic [7:0] blk_base(input logic [7:0] a);
		blk_base = NV_BASE + 8'(blk_of(a) * NV_BLOCK_BYTES);
	endfunction

	assign bus.slave_out = 1'b0;
	assign bus.slave_oe_n = oe_n_reg;
	assign fall = dq_prev_reg & ~bus.dq;
	assign rise = ~dq_prev_reg & bus.dq;
	assign rx_byte = {bus.dq, shift_reg[7:1]};
	assign sample_ev = slot_reg && (cnt_reg == 16'(SAMPLE_POINT_CYC)) && (state_reg != SS_RDATA);
	assign byte_ev = sample_ev && (bit_cnt_reg == 3'd7);
	assign cmd_ev = byte_ev && (state_reg == SS_ADDR);
	// nonvolatile bytes are refused while locked or while a copy runs
	assign wr_ev = byte_ev && (state_reg == SS_WDATA) && !past_end_reg
		&& !(is_nv(addr_reg) && (locked_reg[blk_of(addr_reg)] || copy_busy_flag));

	// ==========================================
	// line watchers
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			dq_prev_reg <= 1'b1;
			low_cnt_reg <= '0;
			sleep_mode <= 1'b0;
		end
		else
		begin
			dq_prev_reg <= bus.dq;
			if (bus.dq)
				low_cnt_reg <= '0;
			else if (low_cnt_reg != '1)
				low_cnt_reg <= low_cnt_reg + 1'b1;
			sleep_mode <= !bus.dq && (low_cnt_reg >= 27'(SLEEP_CYC));
		end
	end

	// ==========================================
	// protocol sequencer and bit engine
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_reg <= SS_IDLE;
			cnt_reg <= '0;
			slot_reg <= 1'b0;
			shift_reg <= '0;
			bit_cnt_reg <= '0;
			op_reg <= '0;
			addr_reg <= '0;
			past_end_reg <= 1'b0;
			oe_n_reg <= 1'b1;
			selected <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_reg + 1'b1;
			if (state_reg != SS_PLOW && !bus.dq && low_cnt_reg > 27'(RESET_DET_CYC))
			begin
				// long low ends whatever was going on, except the slave's own presence pulse
				state_reg <= SS_IDLE;
				slot_reg <= 1'b0;
				oe_n_reg <= 1'b1;
				selected <= 1'b0;
			end
			else if (state_reg != SS_PLOW && rise && low_cnt_reg > 27'(RESET_DET_CYC))
			begin
				cnt_reg <= '0;
				state_reg <= SS_PWAIT;
			end
			else
			begin
				if (fall && state_reg >= SS_ROM && state_reg <= SS_RDATA)
				begin
					// each slot is timed from its own falling edge
					slot_reg <= 1'b1;
					cnt_reg <= '0;
					if (state_reg == SS_RDATA)
						oe_n_reg <= past_end_reg | mem_reg[addr_reg][bit_cnt_reg];
				end
				if (sample_ev)
				begin
					slot_reg <= 1'b0;
					shift_reg <= rx_byte;
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
				end
				case (state_reg)
					SS_PWAIT:
						if (cnt_reg == 16'(PRESENCE_WAIT_CYC - 1))
						begin
							cnt_reg <= '0;
							oe_n_reg <= 1'b0;
							state_reg <= SS_PLOW;
						end
					SS_PLOW:
						if (cnt_reg == 16'(PRES_LOW_CYC - 1))
						begin
							oe_n_reg <= 1'b1;
							bit_cnt_reg <= '0;
							slot_reg <= 1'b0;
							state_reg <= SS_ROM;
						end
					SS_ROM:
						if (byte_ev)
						begin
							selected <= (rx_byte == OP_SKIP_NET);
							state_reg <= (rx_byte == OP_SKIP_NET) ? SS_FUNC : SS_HALT;
						end
					SS_FUNC:
						if (byte_ev)
						begin
							op_reg <= rx_byte;
							state_reg <= (rx_byte == OP_READ || rx_byte == OP_WRITE || rx_byte == OP_COPY
								|| rx_byte == OP_RECALL || rx_byte == OP_LOCK) ? SS_ADDR : SS_HALT;
						end
					SS_ADDR:
						if (byte_ev)
						begin
							addr_reg <= rx_byte;
							past_end_reg <= 1'b0;
							// copy, recall and lock have no data phase
							state_reg <= (op_reg == OP_READ) ? SS_RDATA : (op_reg == OP_WRITE) ? SS_WDATA : SS_HALT;
						end
					SS_WDATA:
						if (byte_ev)
						begin
							addr_reg <= addr_reg + 1'b1;
							if (addr_reg == ADDR_LAST)
								past_end_reg <= 1'b1;
						end
					SS_RDATA:
						if (slot_reg && cnt_reg == 16'(SAMPLE_POINT_CYC))
						begin
							// released well before the shortest slot ends
							oe_n_reg <= 1'b1;
							slot_reg <= 1'b0;
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
							if (bit_cnt_reg == 3'd7)
							begin
								addr_reg <= addr_reg + 1'b1;
								if (addr_reg == ADDR_LAST)
									past_end_reg <= 1'b1; // beyond the top, ones are sent
							end
						end
					SS_IDLE, SS_HALT:
						slot_reg <= 1'b0;
					default:
						state_reg <= SS_IDLE;
				endcase
			end
		end
	end

	// ==========================================
	// shadow memory: data writes and recall
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < 256; i++)
				mem_reg[i] <= MEM_RESET_VALUE;
		end
		else if (wr_ev)
			mem_reg[addr_reg] <= rx_byte;
		else if (cmd_ev && op_reg == OP_RECALL && is_nv(rx_byte))
		begin
			for (int i = 0; i < NV_BLOCK_BYTES; i++)
				mem_reg[blk_base(rx_byte) + 8'(i)] <= nv_reg[blk_of(rx_byte) * NV_BLOCK_BYTES + i];
		end
	end

	// ==========================================
	// nonvolatile store, copy timer and locks
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NV_BYTES; i++)
				nv_reg[i] <= MEM_RESET_VALUE;
			locked_reg <= '0;
			copy_cnt_reg <= '0;
			copy_base_reg <= '0;
			copy_busy_flag <= 1'b0;
		end
		else
		begin
			if (copy_busy_flag)
			begin
				copy_cnt_reg <= copy_cnt_reg + 1'b1;
				if (copy_cnt_reg == 17'(COPY_CYC - 1))
				begin
					// the block is taken at the end; data writes to it are refused meanwhile, a recall to it is not
					for (int i = 0; i < NV_BLOCK_BYTES; i++)
						nv_reg[blk_of(copy_base_reg) * NV_BLOCK_BYTES + i] <= mem_reg[copy_base_reg + 8'(i)];
					copy_busy_flag <= 1'b0;
				end
			end
			else if (cmd_ev && op_reg == OP_COPY && is_nv(rx_byte) && !locked_reg[blk_of(rx_byte)])
			begin
				copy_base_reg <= blk_base(rx_byte);
				copy_cnt_reg <= '0;
				copy_busy_flag <= 1'b1;
			end
			if (cmd_ev && op_reg == OP_LOCK && is_nv(rx_byte) && lock_enable)
				locked_reg[blk_of(rx_byte)] <= 1'b1;
		end
	end
endmodule
